// *** src/avi_status_pkg.sv ***
// constants and types for the infoframe status register bank
package avi_status_pkg;

  // ---------------------------------------------------------------
  // bus geometry and register indices (byte address = 4 * index)
  // ---------------------------------------------------------------
  localparam int          ADDR_W           = 12;
  localparam int          DATA_W           = 32;
  localparam int          IDX_W            = 10;
  localparam logic [9:0]  IDX_ASPECT       = 10'h082;
  localparam logic [9:0]  IDX_SCALING      = 10'h083;
  localparam logic [9:0]  IDX_VFC          = 10'h084;
  localparam logic [9:0]  IDX_PIXREP       = 10'h085;
  localparam logic [9:0]  IDX_TOPBAR_LO    = 10'h086;
  localparam logic [9:0]  IDX_FLAGS        = 10'h087;
  localparam logic [9:0]  IDX_TOPBAR_HI    = 10'h088;
  localparam logic [9:0]  IDX_FLAGS_MIRROR = 10'h08f;
  localparam logic [9:0]  IDX_IRQ_STATUS   = 10'h0a0;
  localparam logic [9:0]  IDX_IRQ_MASK     = 10'h0a1;

  // ---------------------------------------------------------------
  // packet change flag bit positions
  // ---------------------------------------------------------------
  localparam int          NUM_PKT          = 7;
  localparam int          FLAG_AVI         = 0;
  localparam int          FLAG_AUDIO       = 1;
  localparam int          FLAG_SPD         = 2;
  localparam int          FLAG_MPEG        = 3;
  localparam int          FLAG_ACP         = 4;
  localparam int          FLAG_ISRC1       = 5;
  localparam int          FLAG_ISRC2       = 6;

  // ---------------------------------------------------------------
  // field encodings
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    aspect_same   = 4'h8,
    aspect_4_3    = 4'h9,
    aspect_16_9   = 4'ha,
    aspect_14_9   = 4'hb
  } aspect_code_t;

  typedef enum logic [1:0] {
    scale_none    = 2'h0,
    scale_horiz   = 2'h1,
    scale_vert    = 2'h2,
    scale_both    = 2'h3
  } scaling_field_t;

  localparam logic [3:0]  PIXREP_MAX       = 4'h9;
  localparam logic [15:0] TOP_BAR_NONE     = 16'h0000;

  typedef struct packed {
    logic [3:0]  aspect;
    logic [1:0]  scaling_field;
    logic [6:0]  video_format_code;
    logic [3:0]  pixel_repeat_factor;
    logic [15:0] top_bar_end;
  } avi_fields_t;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam avi_fields_t        AVI_RESET   = '0;
  localparam logic [NUM_PKT-1:0] FLAGS_RESET = 7'h00;
  localparam logic [NUM_PKT-1:0] MASK_RESET  = 7'h00;

  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_resp = 2'b01
  } apb_state_t;

endpackage : avi_status_pkg

// *** src/avi_infoframe_status_regs.sv ***
// apb register bank holding decoded avi infoframe fields and change flags
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
module avi_infoframe_status_regs
  import avi_status_pkg::*;
(
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [ADDR_W-1:0]    paddr,
  input  wire logic [DATA_W-1:0]    pwdata,
  input  wire logic [3:0]           pstrb,
  output logic      [DATA_W-1:0]    prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 avi_done,
  input  wire logic                 avi_ok,
  input  wire avi_fields_t          avi_in,
  input  wire logic [NUM_PKT-1:1]   pkt_change,
  output logic                      irq
);

  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------
  function automatic logic is_flag_reg(input logic [IDX_W-1:0] idx);
    is_flag_reg = (idx == IDX_FLAGS) || (idx == IDX_FLAGS_MIRROR);
  endfunction : is_flag_reg

  function automatic logic is_writable(input logic [IDX_W-1:0] idx);
    is_writable = (idx == IDX_IRQ_STATUS) || (idx == IDX_IRQ_MASK);
  endfunction : is_writable

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  apb_state_t           state_q;
  apb_state_t           state_d;
  avi_fields_t          avi_q;
  logic                 avi_seen_q;
  logic [NUM_PKT-1:0]   flags_q;
  logic [NUM_PKT-1:0]   flags_d;
  logic [NUM_PKT-1:0]   status_q;
  logic [NUM_PKT-1:0]   mask_q;
  logic [DATA_W-1:0]    prdata_q;
  logic                 pready_q;
  logic                 pslverr_q;
  logic                 irq_q;

  logic [IDX_W-1:0]     idx;
  logic                 access_start;
  logic                 known;
  logic                 bad;
  logic                 wr_ok;
  logic                 rd_flags;
  logic                 avi_take;
  logic                 avi_diff;
  logic [NUM_PKT-1:0]   set_vec;
  logic [DATA_W-1:0]    rd_word;

  assign idx          = paddr[ADDR_W-1:2];
  assign access_start = psel && penable && (state_q == st_idle);

  // ---------------------------------------------------------------
  // apb handshake: one wait state, then pready for one cycle
  // ---------------------------------------------------------------
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      st_idle:
        if (psel && penable)
        begin
          state_d = st_resp;
        end
      st_resp:
        state_d = st_idle;
      default:
        state_d = st_idle;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= st_idle;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q <= 1'b0;
    end
    else
    begin
      pready_q <= access_start;
    end
  end

  a_pready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && !pready) ##1 (psel && penable) |-> pready ##1 !pready)
    else $error("pready not a single cycle after one wait state");

  a_pready_idle: assert property (@(posedge pclk) disable iff (!presetn)
    !access_start |=> !pready && !pslverr)
    else $error("pready or pslverr without an accepted access");

  // ---------------------------------------------------------------
  // address decode and read mux
  // ---------------------------------------------------------------
  always_comb
  begin
    known = 1'b1;
    rd_word = '0;
    unique case (idx)
      IDX_ASPECT:       rd_word[3:0] = avi_q.aspect;
      IDX_SCALING:      rd_word[1:0] = avi_q.scaling_field;
      IDX_VFC:          rd_word[6:0] = avi_q.video_format_code;
      IDX_PIXREP:       rd_word[3:0] = avi_q.pixel_repeat_factor;
      IDX_TOPBAR_LO:    rd_word[7:0] = avi_q.top_bar_end[7:0];
      IDX_TOPBAR_HI:    rd_word[7:0] = avi_q.top_bar_end[15:8];
      IDX_FLAGS:        rd_word[NUM_PKT-1:0] = flags_q;
      IDX_FLAGS_MIRROR: rd_word[NUM_PKT-1:0] = flags_q;
      IDX_IRQ_STATUS:   rd_word[NUM_PKT-1:0] = status_q;
      IDX_IRQ_MASK:     rd_word[NUM_PKT-1:0] = mask_q;
      default:          known = 1'b0;
    endcase
  end

  assign bad      = !known || (pwrite && !is_writable(idx));
  assign wr_ok    = access_start && pwrite && !bad;
  assign rd_flags = access_start && !pwrite && is_flag_reg(idx);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q  <= '0;
      pslverr_q <= 1'b0;
    end
    else if (access_start)
    begin
      prdata_q  <= (pwrite || bad) ? '0 : rd_word;
      pslverr_q <= bad;
    end
    else
    begin
      pslverr_q <= 1'b0;
    end
  end

  a_mirror_read: assert property (@(posedge pclk) disable iff (!presetn)
    (access_start && !pwrite && is_flag_reg(idx))
    |=> prdata == {{(DATA_W-NUM_PKT){1'b0}}, $past(flags_q)})
    else $error("flag register read did not return the shared flags");

  a_vfc_read: assert property (@(posedge pclk) disable iff (!presetn)
    (access_start && !pwrite && idx == IDX_VFC)
    |=> prdata == {{25{1'b0}}, $past(avi_q.video_format_code)})
    else $error("video format code read mismatch");

  a_topbar_low: assert property (@(posedge pclk) disable iff (!presetn)
    (access_start && !pwrite && idx == IDX_TOPBAR_LO)
    |=> prdata == {24'h000000, $past(avi_q.top_bar_end[7:0])})
    else $error("top bar low byte read mismatch");

  a_topbar_pair: assert property (@(posedge pclk) disable iff (!presetn)
    (access_start && !pwrite && idx == IDX_TOPBAR_HI)
    |=> prdata[7:0] == $past(avi_q.top_bar_end[15:8])
        && prdata[31:8] == 24'h000000)
    else $error("top bar high byte read mismatch");

  a_bad_access: assert property (@(posedge pclk) disable iff (!presetn)
    (access_start && pwrite && !is_writable(idx))
    |=> pslverr && pready)
    else $error("write to read-only or unmapped index not refused");

  a_refused_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (access_start && (pwrite || bad)) |=> prdata == '0)
    else $error("write or refused access returned nonzero data");

  // ---------------------------------------------------------------
  // avi field capture
  // ---------------------------------------------------------------
  assign avi_take = avi_done && avi_ok;
  assign avi_diff = avi_take && (!avi_seen_q || (avi_in != avi_q));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      avi_q      <= AVI_RESET;
      avi_seen_q <= 1'b0;
    end
    else if (avi_take)
    begin
      avi_q      <= avi_in;
      avi_seen_q <= 1'b1;
    end
  end

  a_fields_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !avi_take |=> $stable(avi_q))
    else $error("avi fields changed without a valid packet");

  a_fields_load: assert property (@(posedge pclk) disable iff (!presetn)
    avi_take |=> avi_q == $past(avi_in))
    else $error("avi fields not loaded from valid packet");

  // ---------------------------------------------------------------
  // packet change flags, shared by both flag addresses
  // ---------------------------------------------------------------
  assign set_vec = {pkt_change, avi_diff};

  always_comb
  begin
    // new changes win over a clearing read in the same cycle
    flags_d = (rd_flags ? FLAGS_RESET : flags_q) | set_vec;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      flags_q <= FLAGS_RESET;
    end
    else
    begin
      flags_q <= flags_d;
    end
  end

  a_avi_flag: assert property (@(posedge pclk) disable iff (!presetn)
    (avi_take && avi_seen_q && avi_in != avi_q)
    |=> flags_q[FLAG_AVI])
    else $error("avi change did not raise its flag");

  a_same_avi: assert property (@(posedge pclk) disable iff (!presetn)
    (avi_take && avi_seen_q && avi_in == avi_q && !flags_q[FLAG_AVI])
    |=> !flags_q[FLAG_AVI])
    else $error("unchanged avi packet raised its flag");

  a_flag_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_flags && set_vec == '0) |=> flags_q == FLAGS_RESET)
    else $error("flag read did not clear all flags");

  a_isrc2_flag: assert property (@(posedge pclk) disable iff (!presetn)
    pkt_change[FLAG_ISRC2] |=> flags_q[FLAG_ISRC2] && status_q[FLAG_ISRC2])
    else $error("isrc2 change lost");

  // ---------------------------------------------------------------
  // interrupt status, mask and output
  // ---------------------------------------------------------------
  generate
    for (genvar i = 0; i < NUM_PKT; i++)
    begin : g_status
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          status_q[i] <= 1'b0;
        end
        else if (set_vec[i])
        begin
          status_q[i] <= 1'b1;
        end
        else if (wr_ok && idx == IDX_IRQ_STATUS && pstrb[0] && pwdata[i])
        begin
          status_q[i] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mask_q <= MASK_RESET;
    end
    else if (wr_ok && idx == IDX_IRQ_MASK && pstrb[0])
    begin
      mask_q <= pwdata[NUM_PKT-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_q <= 1'b0;
    end
    else
    begin
      irq_q <= |(status_q & mask_q);
    end
  end

  a_status_w1c: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_ok && idx == IDX_IRQ_STATUS && pstrb[0] && set_vec == '0)
    |=> (status_q & $past(pwdata[NUM_PKT-1:0])) == '0)
    else $error("written ones did not clear interrupt status");

  a_mask_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_ok && idx == IDX_IRQ_MASK && pstrb[0])
    |=> mask_q == $past(pwdata[NUM_PKT-1:0]))
    else $error("mask register did not take the written value");

  a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
    (status_q & mask_q) != '0 |=> irq)
    else $error("irq low although an unmasked status bit is set");

  a_irq_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    (status_q & mask_q) == '0 |=> !irq)
    else $error("irq high with no unmasked status bit set");

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign irq     = irq_q;

endmodule : avi_infoframe_status_regs

// *** dv/avi_source_model.sv ***
// model of the hdmi source delivering decoded infoframe events
`timescale 1ns/1ps
module avi_source_model
  import avi_status_pkg::*;
(
  input  wire logic               pclk,
  output logic                    avi_done,
  output logic                    avi_ok,
  output avi_fields_t             avi_in,
  output logic [NUM_PKT-1:1]      pkt_change
);
  // -------------------------------------------------------------
  // packet delivery
  // -------------------------------------------------------------
  initial
  begin
    avi_done   = 1'b0;
    avi_ok     = 1'b0;
    avi_in     = '1;
    pkt_change = '0;
  end

  // fields are only qualified for one cycle, then scrambled
  task automatic send(input avi_fields_t f, input logic ok);
    avi_in   <= f;
    avi_ok   <= ok;
    avi_done <= 1'b1;
    @(posedge pclk);
    avi_in   <= ~f;
    avi_ok   <= ~ok;
    avi_done <= 1'b0;
    @(posedge pclk);
  endtask : send

  task automatic pulse(input int i);
    logic [NUM_PKT-1:1] v;
    v    = '0;
    v[i] = 1'b1;
    pkt_change <= v;
    @(posedge pclk);
    pkt_change    <= '0;
    @(posedge pclk);
  endtask : pulse
endmodule : avi_source_model

// *** dv/test_avi_infoframe_status_regs.sv ***
// self-checking bench for the infoframe status register bank
`timescale 1ns/1ps
module test_avi_infoframe_status_regs
  import avi_status_pkg::*;
;
  logic                pclk = 1'b0;
  logic                presetn = 1'b0;
  logic                psel = 1'b0;
  logic                penable = 1'b0;
  logic                pwrite = 1'b0;
  logic [ADDR_W-1:0]   paddr = '0;
  logic [DATA_W-1:0]   pwdata = '0;
  logic [DATA_W-1:0]   prdata;
  logic                pready;
  logic                pslverr;
  logic                avi_done;
  logic                avi_ok;
  avi_fields_t         avi_in;
  logic [NUM_PKT-1:1]  pkt_change;
  logic                irq;
  int                  miscompares = 0;
  int                  num_checks = 0;
  logic [31:0]         rd;
  logic                err;
  avi_fields_t         f;

  always #5 pclk = ~pclk;

  avi_infoframe_status_regs dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .avi_done(avi_done), .avi_ok(avi_ok),
    .avi_in(avi_in), .pkt_change(pkt_change), .irq(irq));

  avi_source_model src (.pclk(pclk), .avi_done(avi_done),
    .avi_ok(avi_ok), .avi_in(avi_in), .pkt_change(pkt_change));

  // -------------------------------------------------------------
  // shared tasks
  // -------------------------------------------------------------
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : close_out

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // entered right after a rising edge, returns one edge after the pready edge
  task automatic apb(input logic wr, input logic [9:0] idx,
                     input logic [31:0] wd);
    int n;
    n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (n >= 20)
    begin
      miscompares++;
      close_out();
    end
  endtask : apb

  task automatic rdchk(input string nm, input logic [9:0] idx,
                       input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    chk(nm, rd, exp);
    chk("read_err", err, 32'h0);
  endtask : rdchk

  // -------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------
  task automatic t_reset();
    rdchk("vfc", IDX_VFC, 32'h0);
    rdchk("top_lo", IDX_TOPBAR_LO, 32'h0);
    rdchk("flags", IDX_FLAGS, 32'h0);
    chk("irq", irq, 32'h0);
    $display("test reset done");
  endtask : t_reset

  // every aspect and scaling code, repeat count up to its maximum
  task automatic t_fields();
    logic [7:0] lo;
    for (int i = 0; i < 4; i++)
    begin
      f = '{4'h8 + 4'(i), 2'(i), 7'h11 + 7'(i * 29), 4'(i * 3),
            (i == 0) ? TOP_BAR_NONE : 16'h0a5c + 16'(i * 16'h1101)};
      src.send(f, 1'b1);
      rdchk("aspect", IDX_ASPECT, {28'h0, f.aspect});
      rdchk("scaling", IDX_SCALING, {30'h0, f.scaling_field});
      rdchk("vfc", IDX_VFC, {25'h0, f.video_format_code});
      rdchk("pixrep", IDX_PIXREP, {28'h0, f.pixel_repeat_factor});
      rdchk("top_lo", IDX_TOPBAR_LO, {24'h0, f.top_bar_end[7:0]});
      rdchk("top_hi", IDX_TOPBAR_HI, {24'h0, f.top_bar_end[15:8]});
      rdchk("flags", (i % 2) ? IDX_FLAGS_MIRROR : IDX_FLAGS, 32'h1);
      rdchk("flags", (i % 2) ? IDX_FLAGS : IDX_FLAGS_MIRROR, 32'h0);
    end
    f.top_bar_end = TOP_BAR_NONE;
    src.send(f, 1'b1);
    rdchk("flags", IDX_FLAGS, 32'h1);
    apb(1'b0, IDX_TOPBAR_LO, 32'h0);
    lo = rd[7:0];
    apb(1'b0, IDX_TOPBAR_HI, 32'h0);
    chk("no_bar", {16'h0, rd[7:0], lo}, {16'h0, TOP_BAR_NONE});
    src.send(f, 1'b1);
    rdchk("flags", IDX_FLAGS, 32'h0);
    f.video_format_code = 7'h5a;
    src.send(f, 1'b0);
    rdchk("vfc", IDX_VFC, 32'h68);
    rdchk("flags", IDX_FLAGS, 32'h0);
    $display("test fields done");
  endtask : t_fields

  task automatic t_pkts();
    for (int i = 1; i < NUM_PKT; i++)
    begin
      src.pulse(i);
      rdchk("flag_bit", (i % 2) ? IDX_FLAGS_MIRROR : IDX_FLAGS,
            32'h1 << i);
    end
    src.pulse(FLAG_ISRC1);
    rdchk("mirror", IDX_FLAGS_MIRROR, 32'h20);
    rdchk("mirror", IDX_FLAGS, 32'h0);
    $display("test packets done");
  endtask : t_pkts

  task automatic t_irq();
    apb(1'b1, IDX_IRQ_STATUS, 32'h7f);
    apb(1'b1, IDX_IRQ_MASK, 32'h04);
    rdchk("mask", IDX_IRQ_MASK, 32'h04);
    src.pulse(FLAG_MPEG);
    repeat (2) @(posedge pclk);
    chk("irq_masked", irq, 32'h0);
    src.pulse(FLAG_SPD);
    repeat (2) @(posedge pclk);
    chk("irq_set", irq, 32'h1);
    rdchk("status", IDX_IRQ_STATUS, 32'h0c);
    apb(1'b1, IDX_IRQ_STATUS, 32'h0c);
    repeat (2) @(posedge pclk);
    chk("irq_clear", irq, 32'h0);
    apb(1'b0, 10'h3f0, 32'h0);
    chk("unmapped_err", err, 32'h1);
    chk("unmapped_data", rd, 32'h0);
    apb(1'b1, IDX_VFC, 32'h7f);
    chk("ro_err", err, 32'h1);
    rdchk("vfc", IDX_VFC, 32'h68);
    $display("test irq done");
  endtask : t_irq

  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_fields();
    t_pkts();
    t_irq();
    close_out();
  end
endmodule : test_avi_infoframe_status_regs
